// file: shared/glue_pkg.sv
package glue_pkg;

	// timing base: the glue logic runs from the standby clock domain
	localparam int CLK_MHZ          = 25;
	// hold of resume reset after the standby 5v monitor reports valid
	localparam int RSM_HOLD_US      = 10;
	localparam int RSM_HOLD_CYCLES  = RSM_HOLD_US * CLK_MHZ;
	localparam int RSM_CNT_W        = $clog2(RSM_HOLD_CYCLES + 1);

	// synchroniser depth for every pin input
	localparam int SYNC_STAGES      = 2;

	// reset values of the registered outputs
	localparam logic SUPPLY_ON_RST  = 1'b0;
	localparam logic GATED_PG_RST   = 1'b0;
	localparam logic S3_CUT_RST     = 1'b0;
	localparam logic S5_CUT_RST     = 1'b1;
	localparam logic RSM_RST        = 1'b1;
	localparam logic SCK_GATE_RST   = 1'b1;
	localparam logic LED_RST        = 1'b0;
	localparam logic CODEC_RST_RST  = 1'b1;
	localparam logic CPU_PRES_RST   = 1'b0;

	// sleep-state decode as the controller drives it (s3_n, s5_n)
	localparam logic [1:0] SLP_WORK    = 2'h3;
	localparam logic [1:0] SLEEP_STATE_THREE_N      = 2'h1;
	localparam logic [1:0] SLEEP_STATE_FIVE_N      = 2'h0;
	localparam logic [1:0] SLP_ILLEGAL = 2'h2;

	typedef enum logic [1:0] {
		ST_WORK,
		ST_S3,
		ST_S5
	} power_state_type;

	// every asynchronous pin input, carried together through the synchroniser
	typedef struct packed {
		logic supply_power_good_in;
		logic front_button_reset_n;
		logic processor_present_n;
		logic first_drive_active_n;
		logic second_drive_active_n;
		logic third_drive_active_n;
		logic standby_5v_monitor;
		logic sleep_state_three_n;
		logic sleep_state_five_n;
		logic audio_link_reset_in;
		logic codec_enable_in;
	} pin_inputs_type;

	localparam int PIN_W = $bits(pin_inputs_type);

endpackage : glue_pkg

// file: verilog/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second stage; nothing else looks at it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : sync_two_stage

// file: verilog/board_power_glue_logic.sv
// Operation
// - drive activity led low while any of three drive inputs is low
// - gated power good only while supply good and reset button released
// - front panel reset input low means the button is pressed
// - pull open-drain supply control low to turn main supply on
// - gate memory serial clock off whenever main supply is not valid
// - processor present input low means a processor is installed
// - resume reset held until the standby 5v monitor has reported valid for the hold time
// - open-drain backfeed cut follows entry into and exit from S3
// - latched backfeed cut sets on entry to S5, clears only in working state with supply valid
// - codec enable pin is shared with a port bit that can pull it
// - codec reset output follows audio link reset and codec enable
// - all glue timing runs from the standby clock
// - all glue state is reset only by standby power-up reset
`timescale 1ns/1ps
module board_power_glue_logic
	import glue_pkg::*;
#(
	parameter int RSM_HOLD = RSM_HOLD_CYCLES
) (
	// standby clock and standby power-up reset
	input  wire logic clk,
	input  wire logic arst_n,
	// power supply and front panel pins
	input  wire logic supply_power_good_in,
	input  wire logic front_button_reset_n,
	input  wire logic processor_present_n,
	input  wire logic standby_5v_monitor,
	// drive activity pins
	input  wire logic first_drive_active_n,
	input  wire logic second_drive_active_n,
	input  wire logic third_drive_active_n,
	// sleep state pins from the acpi controller
	input  wire logic sleep_state_three_n,
	input  wire logic sleep_state_five_n,
	// audio link pins
	input  wire logic audio_link_reset_in,
	input  wire logic codec_enable_in,
	// shared port bit from the general-purpose port logic, same clock
	input  wire logic shared_port_bit,
	input  wire logic shared_port_bit_oe,
	// supply control, power good and processor presence
	output logic      main_supply_on_n_oe,
	output logic      gated_power_good_out,
	output logic      processor_installed,
	// backfeed cut controls
	output logic      s3_backfeed_cut_oe,
	output logic      s5_latched_feed_cut,
	// resets, gates and drive activity led
	output logic      resume_reset_out,
	output logic      memory_serial_clock_gate_oe,
	output logic      drive_activity_led_n_oe,
	output logic      codec_reset_out
);

	pin_inputs_type  pins_raw;
	pin_inputs_type  pins_s;
	logic [PIN_W-1:0] pins_sync;

	power_state_type state_r;
	power_state_type state_nxt;
	logic [RSM_CNT_W-1:0] rsm_cnt_r;
	logic [RSM_CNT_W-1:0] rsm_cnt_nxt;

	// bundle the pins so they cross into the clock domain together
	assign pins_raw = '{
		supply_power_good_in:  supply_power_good_in,
		front_button_reset_n:  front_button_reset_n,
		processor_present_n:   processor_present_n,
		first_drive_active_n:  first_drive_active_n,
		second_drive_active_n: second_drive_active_n,
		third_drive_active_n:  third_drive_active_n,
		standby_5v_monitor:    standby_5v_monitor,
		sleep_state_three_n:   sleep_state_three_n,
		sleep_state_five_n:    sleep_state_five_n,
		audio_link_reset_in:   audio_link_reset_in,
		codec_enable_in:       codec_enable_in
	};

	// two flip-flops on every pin before any logic reads it
	// limitation: pins that move together may still land one edge apart,
	// so the sleep decode must ride out a passing illegal code
	sync_two_stage #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	assign pins_s = pin_inputs_type'(pins_sync);

	// decoded levels, named by meaning
	wire       supply_valid;
	wire       button_pressed;
	wire       any_drive_active;
	wire       cpu_in_socket;
	wire       rsm_supply_ok;
	wire       codec_enabled;
	wire       gated_pg_nxt;
	wire       supply_on_nxt;
	wire       s3_cut_nxt;
	wire       s5_cut_nxt;
	wire       rsm_nxt;
	wire       codec_rst_nxt;
	wire [1:0] sleep_code;

	assign supply_valid     = pins_s.supply_power_good_in;
	assign button_pressed   = ~pins_s.front_button_reset_n;
	assign cpu_in_socket    = ~pins_s.processor_present_n;
	assign rsm_supply_ok    = pins_s.standby_5v_monitor;
	assign any_drive_active = ~(pins_s.first_drive_active_n
		& pins_s.second_drive_active_n
		& pins_s.third_drive_active_n);
	assign sleep_code = {pins_s.sleep_state_three_n,
		pins_s.sleep_state_five_n};

	// the port bit pulls the shared pin low like a wired-and when it drives
	assign codec_enabled = pins_s.codec_enable_in
		& ~(shared_port_bit_oe & ~shared_port_bit);

	// power state follows the sleep pins; an illegal code keeps the state
	// so a glitch between the two pins cannot drop the main supply
	always_comb begin
		state_nxt = state_r;
		unique case (sleep_code)
			SLP_WORK:    state_nxt = ST_WORK;
			SLEEP_STATE_THREE_N:      state_nxt = ST_S3;
			SLEEP_STATE_FIVE_N:      state_nxt = ST_S5;
			SLP_ILLEGAL: state_nxt = state_r;
		endcase
	end

	// main supply is requested only in the working state
	assign supply_on_nxt = (state_nxt == ST_WORK);

	// gated power good combines supply good and the released button
	assign gated_pg_nxt = supply_valid & ~button_pressed;

	// s3 cut is active while the system sits in S3
	// a high enable pulls the open-drain cut pin low
	assign s3_cut_nxt = (state_nxt == ST_S3);

	// s5 cut sets on entry to S5 and clears only once the system is back
	// in the working state with a valid supply, so a short S3 pass keeps it
	assign s5_cut_nxt = (state_nxt == ST_S5) ? 1'b1
		: ((state_nxt == ST_WORK) & supply_valid) ? 1'b0
		: s5_latched_feed_cut;

	// the link reset is synchronised like every other pin
	wire link_reset;
	assign link_reset = pins_s.audio_link_reset_in;

	// codec stays in reset while the link resets it or it is disabled;
	// either source alone is enough, so a stuck enable cannot free it
	assign codec_rst_nxt = link_reset | ~codec_enabled;

	// resume reset counter restarts whenever the 5v monitor drops
	// it saturates at the hold so a long run never wraps back to zero
	// and drops the resume reset onto a running system
	function automatic logic [RSM_CNT_W-1:0] count_up(
		input logic [RSM_CNT_W-1:0] cnt,
		input logic                 ok
	);
		if (!ok)
			return '0;
		else if (cnt < RSM_CNT_W'(RSM_HOLD))
			return cnt + RSM_CNT_W'(1);
		else
			return cnt;
	endfunction : count_up

	// resume reset stands while the monitor is low or the hold still runs
	assign rsm_cnt_nxt = count_up(rsm_cnt_r, rsm_supply_ok);
	assign rsm_nxt = ~rsm_supply_ok
		| (rsm_cnt_nxt < RSM_CNT_W'(RSM_HOLD));

	// state and resume counter; only the standby power-up reset clears them
	// reset lands in S5 so the main supply stays off until the sleep pins
	// have come through the synchroniser
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= ST_S5;
			rsm_cnt_r <= '0;
		end else begin
			state_r   <= state_nxt;
			rsm_cnt_r <= rsm_cnt_nxt;
		end
	end

	// every output comes from a flip-flop
	// limitation: a pin pulse shorter than one clock may never show
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			main_supply_on_n_oe         <= SUPPLY_ON_RST;
			gated_power_good_out        <= GATED_PG_RST;
			processor_installed         <= CPU_PRES_RST;
			s3_backfeed_cut_oe          <= S3_CUT_RST;
			s5_latched_feed_cut         <= S5_CUT_RST;
			resume_reset_out            <= RSM_RST;
			memory_serial_clock_gate_oe <= SCK_GATE_RST;
			drive_activity_led_n_oe     <= LED_RST;
			codec_reset_out             <= CODEC_RST_RST;
		end else begin
			main_supply_on_n_oe         <= supply_on_nxt;
			gated_power_good_out        <= gated_pg_nxt;
			processor_installed         <= cpu_in_socket;
			s3_backfeed_cut_oe          <= s3_cut_nxt;
			s5_latched_feed_cut         <= s5_cut_nxt;
			resume_reset_out            <= rsm_nxt;
			memory_serial_clock_gate_oe <= ~supply_valid;
			drive_activity_led_n_oe     <= any_drive_active;
			codec_reset_out             <= codec_rst_nxt;
		end
	end

endmodule : board_power_glue_logic

// file: dv/board_power_glue_logic_assertions.sv
`timescale 1ns/1ps
module glue_checker
	import glue_pkg::*;
#(
	parameter int RSM_HOLD = RSM_HOLD_CYCLES
) (
	// clock, reset and pins
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_power_good_in,
	input wire logic front_button_reset_n,
	input wire logic standby_5v_monitor,
	input wire logic first_drive_active_n,
	input wire logic second_drive_active_n,
	input wire logic third_drive_active_n,
	input wire logic sleep_state_three_n,
	input wire logic sleep_state_five_n,
	// glue outputs
	input wire logic main_supply_on_n_oe,
	input wire logic gated_power_good_out,
	input wire logic s3_backfeed_cut_oe,
	input wire logic s5_latched_feed_cut,
	input wire logic resume_reset_out,
	input wire logic memory_serial_clock_gate_oe,
	input wire logic drive_activity_led_n_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// run of monitor-high edges, saturating so a long run never wraps
	logic [7:0] mon_run_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mon_run_r <= 8'h00;
		else if (!standby_5v_monitor)
			mon_run_r <= 8'h00;
		else if (mon_run_r != 8'hFF)
			mon_run_r <= mon_run_r + 8'h01;
	end

	// sleep codes as the controller drives them
	sequence work_code; sleep_state_three_n && sleep_state_five_n; endsequence
	sequence s3_code; !sleep_state_three_n && sleep_state_five_n; endsequence
	sequence s5_code; !sleep_state_three_n && !sleep_state_five_n; endsequence

	chk_led_any_on: assert property (
		!(first_drive_active_n && second_drive_active_n && third_drive_active_n)
		|-> ##3 drive_activity_led_n_oe) else $error("led not lit");
	chk_pg_good: assert property (
		(supply_power_good_in && front_button_reset_n)
		|-> ##3 gated_power_good_out) else $error("power good missing");
	chk_pg_pressed: assert property (
		!front_button_reset_n |-> ##3 !gated_power_good_out)
		else $error("power good while button pressed");
	chk_sck_gate: assert property (
		!supply_power_good_in |-> ##3 memory_serial_clock_gate_oe)
		else $error("memory clock path left open");
	chk_supply_work: assert property (
		work_code |-> ##3 main_supply_on_n_oe && !s3_backfeed_cut_oe)
		else $error("working state outputs wrong");
	chk_s3_cut: assert property (
		s3_code |-> ##3 s3_backfeed_cut_oe && $stable(s5_latched_feed_cut))
		else $error("s3 outputs wrong");
	chk_s5_latch: assert property (
		s5_code |-> ##3 s5_latched_feed_cut && !main_supply_on_n_oe)
		else $error("s5 outputs wrong");
	chk_resume_hold: assert property (
		!standby_5v_monitor |-> ##3 resume_reset_out)
		else $error("resume reset released early");
	chk_resume_free: assert property (
		mon_run_r > RSM_HOLD + 5 |-> !resume_reset_out)
		else $error("resume reset stuck");
endmodule : glue_checker

bind board_power_glue_logic glue_checker #(.RSM_HOLD(RSM_HOLD)) chk (.*);

// file: dv/psu_model.sv
`timescale 1ns/1ps
module psu_model (
	// standby clock
	input wire logic clk,
	// supply control in, power good back
	input wire logic supply_on,
	output logic     power_good
);
	// cycles since the supply was switched on, capped
	int unsigned on_cnt = 0;
	always @(negedge clk) begin
		if (!supply_on)
			on_cnt <= 0;
		else if (on_cnt < 8)
			on_cnt <= on_cnt + 1;
	end
	// good only after the rail settles, gone as soon as it is off
	assign power_good = supply_on && on_cnt >= 4;
endmodule : psu_model

// file: dv/test_board_power_glue_logic.sv
`timescale 1ns/1ps
module test_board_power_glue_logic;
	import glue_pkg::*;
	// short resume hold so its release shows in a brief run
	localparam int HOLD = 4;
	localparam logic [8:0] RST_OUT = {SUPPLY_ON_RST, GATED_PG_RST,
		CPU_PRES_RST, S3_CUT_RST, S5_CUT_RST, RSM_RST, SCK_GATE_RST,
		LED_RST, CODEC_RST_RST};
	logic            clk = 1'b0;
	logic            arst_n = 1'b0;
	logic            pob = 1'b0;
	logic            pb = 1'b0;
	logic            po_r;
	logic            pb_r;
	logic            lat;
	wire             power_good;
	wire [8:0]       g;
	pin_inputs_type  p = '0;
	pin_inputs_type  h [0:2];
	power_state_type st;
	int              n_mismatch = 0;
	int              n_tests = 0;
	int              seed = 28204;
	int              mc;

	board_power_glue_logic #(.RSM_HOLD(HOLD)) dut (
		.clk, .arst_n, .supply_power_good_in(power_good),
		.front_button_reset_n(p.front_button_reset_n),
		.processor_present_n(p.processor_present_n),
		.standby_5v_monitor(p.standby_5v_monitor),
		.first_drive_active_n(p.first_drive_active_n),
		.second_drive_active_n(p.second_drive_active_n),
		.third_drive_active_n(p.third_drive_active_n),
		.sleep_state_three_n(p.sleep_state_three_n),
		.sleep_state_five_n(p.sleep_state_five_n),
		.audio_link_reset_in(p.audio_link_reset_in),
		.codec_enable_in(p.codec_enable_in),
		.shared_port_bit(pb), .shared_port_bit_oe(pob),
		.main_supply_on_n_oe(g[8]), .gated_power_good_out(g[7]),
		.processor_installed(g[6]), .s3_backfeed_cut_oe(g[5]),
		.s5_latched_feed_cut(g[4]), .resume_reset_out(g[3]),
		.memory_serial_clock_gate_oe(g[2]), .drive_activity_led_n_oe(g[1]),
		.codec_reset_out(g[0])
	);
	psu_model u_psu (.clk, .supply_on(g[8]), .power_good);

	initial forever #20 clk = ~clk;

	// pin history as the synchroniser stages see it
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			h <= '{default: '0};
		end else begin
			h <= '{p, h[0], h[1]};
			h[0].supply_power_good_in <= power_good;
			po_r <= pob;
			pb_r <= pb;
		end
	end

	task check(input logic [8:0] e, input logic [8:0] m);
		n_tests++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask : check

	// reference model, one step per clock from the synchronised pins
	task step;
		pin_inputs_type d;
		logic [8:0]     e;
		d = h[2];
		if (!arst_n) begin
			st = ST_S5;
			lat = 1'b1;
			mc = 0;
			check(RST_OUT, 9'h1FF);
		end else begin
			if ({d.sleep_state_three_n, d.sleep_state_five_n} == SLP_WORK)
				st = ST_WORK;
			else if ({d.sleep_state_three_n, d.sleep_state_five_n} == SLEEP_STATE_THREE_N)
				st = ST_S3;
			else if ({d.sleep_state_three_n, d.sleep_state_five_n} == SLEEP_STATE_FIVE_N)
				st = ST_S5;
			if (st == ST_S5)
				lat = 1'b1;
			else if (st == ST_WORK && d.supply_power_good_in)
				lat = 1'b0;
			mc = d.standby_5v_monitor ? mc + 1 : 0;
			e = {st == ST_WORK, d.supply_power_good_in & d.front_button_reset_n,
				!d.processor_present_n, st == ST_S3, lat, mc < HOLD,
				!d.supply_power_good_in, !(d.first_drive_active_n &
				d.second_drive_active_n & d.third_drive_active_n),
				d.audio_link_reset_in | !(d.codec_enable_in & !(po_r & !pb_r))};
			// resume reset stands until the monitor was good for HOLD edges
			check(e, 9'h1F0);
			check(e, 9'h00F);
		end
	endtask : step

	// random pins; the sleep code mostly holds so the supply can settle
	task drive;
		logic [31:0] r;
		logic [1:0]  s;
		r = $random(seed);
		s = {p.sleep_state_three_n, p.sleep_state_five_n};
		p = pin_inputs_type'(r[10:0]);
		p.standby_5v_monitor = |r[15:11];
		p.front_button_reset_n = |r[17:16];
		if (r[21:18] != 4'h0)
			{p.sleep_state_three_n, p.sleep_state_five_n} = s;
		pob = r[22];
		pb = r[23];
	endtask : drive

	task run(input int n);
		repeat (n) begin
			@(negedge clk);
			step;
			drive;
		end
	endtask : run

	task test_done;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	initial begin
		run(16);
		$display("reset test done");
		arst_n = 1'b1;
		run(3000);
		$display("random test done");
		arst_n = 1'b0;
		run(4);
		arst_n = 1'b1;
		run(2000);
		$display("second reset test done");
		test_done;
	end

	// watchdog well beyond the planned 5020 cycles
	initial begin
		#(8000 * 40);
		n_mismatch++;
		test_done;
	end
endmodule : test_board_power_glue_logic
